// [logic/fmsp_pkg.sv]
package fmsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses and reset value
  localparam logic [7:0] CTL_ADDR = 8'h98;
  localparam logic [7:0] DAT_ADDR = 8'h99;
  localparam logic [7:0] CTL_RST = 8'h00;

  // control register field positions
  localparam int P_MSEL_HI = 7;
  localparam int P_MSEL_LO = 6;
  localparam int P_MPE = 5;
  localparam int P_REN = 4;
  localparam int P_TX9 = 3;
  localparam int P_RX9 = 2;
  localparam int P_TXF = 1;
  localparam int P_RXF = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: ticks per bit and divider figures
  localparam int OVS_TICKS = 16;
  localparam int OVS_MID = OVS_TICKS / 2 - 1;
  localparam int M2_DIV_NORM = 64;
  localparam int M2_DIV_DBL = 32;
  localparam int M2_TICK_NORM = M2_DIV_NORM / OVS_TICKS;
  localparam int M2_TICK_DBL = M2_DIV_DBL / OVS_TICKS;
  localparam int SYNC_LAT = 3;
  localparam int TX_FIFO_DEPTH = 16;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // modes and engine states
  typedef enum logic [1:0] {
    FMSP_M_SHIFT = 2'b00,
    FMSP_M_UART8 = 2'b01,
    FMSP_M_UART9F = 2'b10,
    FMSP_M_UART9V = 2'b11
  } fmsp_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_ASYNC = 2'b10,
    TX_SH0 = 2'b11
  } fmsp_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_SH0 = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b011
  } fmsp_rx_e;

  // core register port request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } fmsp_sfr_req_s;

endpackage : fmsp_pkg

// [logic/fmsp_fifo.sv]
module fmsp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two, at least two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
    end
  end

endmodule : fmsp_fifo

// [logic/fmsp_top.sv]
// Behaviour
// - a held byte stays while the next frame shifts; late frame meets full holder
// - data port write feeds transmit path, read returns a separate receive holder
// - two mode bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable
// - shift register mode moves one bit every two core clocks
// - 9-bit fixed mode bit is core clock over 64, over 32 when doubled
// - 8-bit mode with multiprocessor enable needs a good stop bit to flag
// - 9-bit modes with multiprocessor enable drop frames whose ninth bit is 0
// - 9-bit modes send the transmit ninth-bit control as ninth bit
// - receive ninth bit takes ninth bit, or stop bit in 8-bit mode
// - transmit flag sets after eighth shift bit or at stop start; software clears
// - receive flag sets after eighth shift bit or mid stop; software clears
// - shift mode: data on receive pin, clock on transmit pin, lsb first
// - shift mode receive starts when enabled and receive flag clear
// - 8-bit frame: start 0, eight data lsb first, stop 1
// - 8-bit mode loads a 1 as ninth shift bit, sent as stop
// - async receive starts on falling edge, skips start bit, shifts data
// - last shift updates data, ninth bit, flag only when flag clear and filter passes
// - 9-bit frame: start, eight data lsb first, ninth bit, stop
// - 9-bit transmit starts at the next bit-rate tick after a load
// - variable modes take timer 1 or timer 2 overflows per direction
// - clock-source controls pick timer 2 per direction in variable modes
// - timer 2 source needs 16 overflows per bit
module fmsp_top #(
  parameter int FIFO_DEPTH = fmsp_pkg::TX_FIFO_DEPTH
) (
  // clock, reset, freeze
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // core register port
  input wire fmsp_pkg::fmsp_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic tx_space,
  // bit-rate sources and controls
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  input wire logic baud_double,
  input wire logic rx_clock_source,
  input wire logic tx_clock_source,
  // serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam int DW = fmsp_pkg::DATA_W;

  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] rx_hold_reg;
  logic [7:0] rdata_reg;
  logic space_reg;
  fmsp_pkg::fmsp_mode_e mode;
  logic wr_ctl;
  logic wr_dat;

  logic rxd_meta_reg;
  logic rxd_s_reg;
  logic rxd_d_reg;

  logic [1:0] m2_cnt_reg;
  logic [1:0] m2_lim;
  logic m2_tick;
  logic t1_half_reg;
  logic t1_tick;
  logic tx_tick;
  logic rx_tick;

  logic fifo_ready;
  logic fifo_valid;
  logic [DW:0] fifo_data;
  logic tx_take;
  logic fifo_pop;

  fmsp_pkg::fmsp_tx_e tx_st_reg;
  logic [10:0] tx_frame_reg;
  logic [3:0] tx_sub_reg;
  logic [3:0] tx_idx_reg;
  logic [3:0] tx_last;
  logic tx_line_reg;
  logic ti_pulse_reg;

  fmsp_pkg::fmsp_rx_e rx_st_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_sub_reg;
  logic [3:0] rx_idx_reg;
  logic [3:0] rx_last;
  logic rx_cdone_reg;
  logic [2:0] rx_pipe_reg;
  logic rx_fin_reg;
  logic rx_ok;

  logic txd_next;
  logic rxd_next;
  logic oe_next;
  logic txd_reg;
  logic rxd_reg;
  logic oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // bit-rate tick source per direction for the current mode
  function automatic logic pick_tick(
    input fmsp_pkg::fmsp_mode_e m,
    input logic use_t2,
    input logic m2,
    input logic t1,
    input logic t2
  );
    logic r;
    r = 1'b0;
    case (m)
      fmsp_pkg::FMSP_M_UART9F: r = m2;
      fmsp_pkg::FMSP_M_UART8,
      fmsp_pkg::FMSP_M_UART9V: r = use_t2 ? t2 : t1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_tick

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign mode = fmsp_pkg::fmsp_mode_e'(
    ctl_reg[fmsp_pkg::P_MSEL_HI:fmsp_pkg::P_MSEL_LO]);
  assign wr_ctl = sfr_req.wr && (sfr_req.addr == fmsp_pkg::CTL_ADDR);
  assign wr_dat = sfr_req.wr && (sfr_req.addr == fmsp_pkg::DAT_ADDR);

  // read mux, registered; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (clk_en && sfr_req.rd) begin
      if (sfr_req.addr == fmsp_pkg::CTL_ADDR) rdata_reg <= ctl_reg;
      else if (sfr_req.addr == fmsp_pkg::DAT_ADDR) rdata_reg <= rx_hold_reg;
      else rdata_reg <= 8'h00;
    end
  end

  // control next value: hardware sets win over software writes
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) ctl_next = sfr_req.wdata;
    if (ti_pulse_reg) ctl_next[fmsp_pkg::P_TXF] = 1'b1;
    if (rx_ok) begin
      ctl_next[fmsp_pkg::P_RXF] = 1'b1;
      if (mode != fmsp_pkg::FMSP_M_SHIFT) begin
        ctl_next[fmsp_pkg::P_RX9] = rx_sh_reg[8];
      end
    end
  end

  // control register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) ctl_reg <= fmsp_pkg::CTL_RST;
    else if (clk_en) ctl_reg <= ctl_next;
  end

  // receive holder, separate from transmit storage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_hold_reg <= 8'h00;
    end else if (clk_en && rx_ok) begin
      if (mode == fmsp_pkg::FMSP_M_SHIFT) rx_hold_reg <= rx_sh_reg[8:1];
      else rx_hold_reg <= rx_sh_reg[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive pin synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_s_reg <= 1'b1;
      rxd_d_reg <= 1'b1;
    end else if (clk_en) begin
      rxd_meta_reg <= rxd_in;
      rxd_s_reg <= rxd_meta_reg;
      rxd_d_reg <= rxd_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit-rate ticks, sixteen per bit
  assign m2_lim = baud_double ? 2'(fmsp_pkg::M2_TICK_DBL - 1)
                              : 2'(fmsp_pkg::M2_TICK_NORM - 1);
  assign m2_tick = (m2_cnt_reg == m2_lim);
  assign t1_tick = t1_ovf && (baud_double || t1_half_reg);
  assign tx_tick = pick_tick(mode, tx_clock_source, m2_tick, t1_tick, t2_ovf);
  assign rx_tick = pick_tick(mode, rx_clock_source, m2_tick, t1_tick, t2_ovf);

  // fixed-rate divider
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) m2_cnt_reg <= 2'h0;
    else if (clk_en) m2_cnt_reg <= m2_tick ? 2'h0 : m2_cnt_reg + 2'h1;
  end

  // timer 1 halving unless doubled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) t1_half_reg <= 1'b0;
    else if (clk_en && t1_ovf) t1_half_reg <= ~t1_half_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit queue
  assign tx_take = (tx_st_reg == fmsp_pkg::TX_IDLE) &&
                   (mode != fmsp_pkg::FMSP_M_SHIFT || rx_st_reg != fmsp_pkg::RX_SH0);
  assign fifo_pop = tx_take && fifo_valid;

  fmsp_fifo #(
    .WIDTH(DW + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .in_valid(wr_dat),
    .in_ready(fifo_ready),
    .in_data({ctl_reg[fmsp_pkg::P_TX9], sfr_req.wdata}),
    .out_valid(fifo_valid),
    .out_ready(tx_take),
    .out_data(fifo_data)
  );

  // queue space flag to the core
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) space_reg <= 1'b1;
    else if (clk_en) space_reg <= fifo_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  assign tx_last = (mode == fmsp_pkg::FMSP_M_UART8) ? 4'h9 : 4'ha;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_reg <= fmsp_pkg::TX_IDLE;
      tx_frame_reg <= 11'h7ff;
      tx_sub_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_line_reg <= 1'b1;
      ti_pulse_reg <= 1'b0;
    end else if (clk_en) begin
      ti_pulse_reg <= 1'b0;
      case (tx_st_reg)
        fmsp_pkg::TX_IDLE: begin
          tx_line_reg <= 1'b1;
          tx_sub_reg <= 4'h0;
          tx_idx_reg <= 4'h0;
          if (fifo_pop) begin
            if (mode == fmsp_pkg::FMSP_M_SHIFT) begin
              tx_frame_reg <= {3'h7, fifo_data[7:0]};
              tx_st_reg <= fmsp_pkg::TX_SH0;
            end else begin
              tx_frame_reg <= {1'b1,
                (mode == fmsp_pkg::FMSP_M_UART8) ? 1'b1 : fifo_data[8],
                fifo_data[7:0], 1'b0};
              tx_st_reg <= fmsp_pkg::TX_WAIT;
            end
          end
        end
        fmsp_pkg::TX_WAIT: begin
          if (tx_tick) begin
            tx_line_reg <= tx_frame_reg[0];
            tx_st_reg <= fmsp_pkg::TX_ASYNC;
          end
        end
        fmsp_pkg::TX_ASYNC: begin
          if (tx_tick) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == 4'(fmsp_pkg::OVS_TICKS - 1)) begin
              if (tx_idx_reg == tx_last) begin
                tx_line_reg <= 1'b1;
                tx_st_reg <= fmsp_pkg::TX_IDLE;
              end else begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
                tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                tx_line_reg <= tx_frame_reg[1];
                if (tx_idx_reg + 4'h1 == tx_last) ti_pulse_reg <= 1'b1;
              end
            end
          end
        end
        fmsp_pkg::TX_SH0: begin
          tx_sub_reg <= tx_sub_reg + 4'h1;
          if (tx_sub_reg[0]) begin
            if (tx_idx_reg == 4'h7) begin
              ti_pulse_reg <= 1'b1;
              tx_st_reg <= fmsp_pkg::TX_IDLE;
            end else begin
              tx_idx_reg <= tx_idx_reg + 4'h1;
              tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
            end
          end
        end
        default: tx_st_reg <= fmsp_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  assign rx_last = (mode == fmsp_pkg::FMSP_M_UART8) ? 4'h8 : 4'h9;
  assign rx_ok = rx_fin_reg && !ctl_reg[fmsp_pkg::P_RXF] &&
                 (!ctl_reg[fmsp_pkg::P_MPE] || rx_sh_reg[8] ||
                  mode == fmsp_pkg::FMSP_M_SHIFT);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_reg <= fmsp_pkg::RX_IDLE;
      rx_sh_reg <= 9'h000;
      rx_sub_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_cdone_reg <= 1'b0;
      rx_pipe_reg <= 3'h0;
      rx_fin_reg <= 1'b0;
    end else if (clk_en) begin
      rx_fin_reg <= 1'b0;
      case (rx_st_reg)
        fmsp_pkg::RX_IDLE: begin
          rx_sub_reg <= 4'h0;
          rx_idx_reg <= 4'h0;
          rx_cdone_reg <= 1'b0;
          rx_pipe_reg <= 3'h0;
          if (ctl_reg[fmsp_pkg::P_REN]) begin
            if (mode == fmsp_pkg::FMSP_M_SHIFT) begin
              if (!ctl_reg[fmsp_pkg::P_RXF] && !fifo_valid && !rx_fin_reg &&
                  tx_st_reg == fmsp_pkg::TX_IDLE) begin
                rx_st_reg <= fmsp_pkg::RX_SH0;
              end
            end else if (rxd_d_reg && !rxd_s_reg) begin
              rx_st_reg <= fmsp_pkg::RX_START;
            end
          end
        end
        fmsp_pkg::RX_SH0: begin
          if (!rx_cdone_reg) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'hf) rx_cdone_reg <= 1'b1;
          end
          // sample after the pin round trip
          rx_pipe_reg <= {rx_pipe_reg[1:0], !rx_cdone_reg && rx_sub_reg[0]};
          if (rx_pipe_reg[fmsp_pkg::SYNC_LAT - 1]) begin
            rx_sh_reg <= {rxd_s_reg, rx_sh_reg[8:1]};
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h7) begin
              rx_fin_reg <= 1'b1;
              rx_st_reg <= fmsp_pkg::RX_IDLE;
            end
          end
        end
        fmsp_pkg::RX_START: begin
          if (rx_tick) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'(fmsp_pkg::OVS_MID)) begin
              rx_sub_reg <= 4'h0;
              if (rxd_s_reg) rx_st_reg <= fmsp_pkg::RX_IDLE;
              else rx_st_reg <= fmsp_pkg::RX_DATA;
            end
          end
        end
        fmsp_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'(fmsp_pkg::OVS_TICKS - 1)) begin
              rx_sub_reg <= 4'h0;
              rx_idx_reg <= rx_idx_reg + 4'h1;
              if (rx_idx_reg < 4'h9) rx_sh_reg <= {rxd_s_reg, rx_sh_reg[8:1]};
              if (rx_idx_reg == rx_last) begin
                rx_fin_reg <= 1'b1;
                rx_st_reg <= fmsp_pkg::RX_IDLE;
              end
            end
          end
        end
        default: rx_st_reg <= fmsp_pkg::RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: shift mode uses receive pin for data, transmit pin for clock
  always_comb begin
    txd_next = tx_line_reg;
    rxd_next = 1'b1;
    oe_next = 1'b0;
    if (tx_st_reg == fmsp_pkg::TX_SH0) begin
      txd_next = tx_sub_reg[0];
      rxd_next = tx_frame_reg[0];
      oe_next = 1'b1;
    end else if (rx_st_reg == fmsp_pkg::RX_SH0) begin
      txd_next = rx_cdone_reg | rx_sub_reg[0];
    end
  end

  // registered pin outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txd_reg <= 1'b1;
      rxd_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else if (clk_en) begin
      txd_reg <= txd_next;
      rxd_reg <= rxd_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sfr_rdata = rdata_reg;
  assign tx_space = space_reg;
  assign txd_out = txd_reg;
  assign rxd_out = rxd_reg;
  assign rxd_oe = oe_reg;

endmodule : fmsp_top

// [tb/fmsp_props.sv]
module fmsp_props #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input wire fmsp_pkg::fmsp_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic tx_space,
  // serial pins
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  logic rd_ok;
  logic seen_wr_reg;
  logic txd_q_reg;
  logic [3:0] rise_cnt_reg;
  assign rd_ok = sfr_req.rd && clk_en;

  // any write since reset, and shift clock rises per drive burst
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_wr_reg <= 1'b0;
      txd_q_reg <= 1'b1;
      rise_cnt_reg <= 4'h0;
    end else begin
      seen_wr_reg <= seen_wr_reg | (sfr_req.wr & clk_en);
      txd_q_reg <= txd_out;
      if (!rxd_oe) rise_cnt_reg <= 4'h0;
      else if (txd_out && !txd_q_reg) rise_cnt_reg <= rise_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_clk_pulse;
    !txd_out ##1 txd_out;
  endsequence

  a_rdata_hold: assert property (!rd_ok |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_ok && sfr_req.addr != fmsp_pkg::CTL_ADDR &&
    sfr_req.addr != fmsp_pkg::DAT_ADDR |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_reset: assert property (rd_ok && sfr_req.addr == fmsp_pkg::CTL_ADDR &&
    !seen_wr_reg |=> sfr_rdata == fmsp_pkg::CTL_RST)
    else $error("control not at reset value");
  a_no_tx_unasked: assert property (!seen_wr_reg |-> txd_out && !rxd_oe && tx_space)
    else $error("pins active before any write");
  a_reset_idle: assert property (disable iff (1'b0) !arst_n |-> txd_out && !rxd_oe)
    else $error("pins not idle in reset");
  a_shift_rate: assert property ($fell(txd_out) && rxd_oe |-> s_clk_pulse)
    else $error("shift clock low phase not one cycle");
  a_shift_hold: assert property ($rose(txd_out) && rxd_oe |-> $stable(rxd_out))
    else $error("shift data changed at clock rise");
  a_shift_eight: assert property ($fell(rxd_oe) |-> rise_cnt_reg inside {4'h7, 4'h8})
    else $error("shift burst not eight clocks");
endmodule : fmsp_props

bind fmsp_top fmsp_props #(.FIFO_DEPTH(FIFO_DEPTH)) props_u (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .tx_space(tx_space),
  .rxd_out(rxd_out),
  .rxd_oe(rxd_oe),
  .txd_out(txd_out)
);

// [tb/fmsp_remote.sv]
module fmsp_remote (
  // clock
  input wire logic sys_clk,
  // device pins
  input wire logic txd_out,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_reg = 1'b1;

  // receive wire: device drive wins, else our drive, idle high
  assign rxd_in = rxd_oe ? rxd_out : drv_reg;

  // send n bits lsb first, each cyc cycles, then idle high
  task automatic send(input int cyc, input int n, input logic [10:0] bits);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      drv_reg <= bits[i];
      repeat (cyc - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    drv_reg <= 1'b1;
  endtask : send

  // measure start bit length, then sample each bit at mid period
  task automatic recv(input int cyc, input int n, output logic [10:0] bits, output int len);
    @(negedge txd_out);
    len = 0;
    bits = 11'h000;
    while (txd_out !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      len++;
    end
    for (int i = 1; i < n; i++) begin
      repeat ((i == 1) ? cyc / 2 : cyc) @(posedge sys_clk);
      #1;
      bits[i] = txd_out;
    end
  endtask : recv

  // shift mode: take the wire level at each clock rise
  task automatic shift_cap(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_out);
      #1;
      b[i] = rxd_in;
    end
  endtask : shift_cap

  // shift mode: new bit at each clock fall, held through the rise until the next fall
  task automatic shift_give(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_out);
      drv_reg <= b[i];
    end
    repeat (4) @(posedge sys_clk);
    drv_reg <= 1'b1;
  endtask : shift_give
endmodule : fmsp_remote

// [tb/fmsp_top_tb.sv]
module fmsp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = fmsp_pkg::CTL_ADDR;
  localparam logic [7:0] DAT = fmsp_pkg::DAT_ADDR;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b1;
  logic clk_en = 1'b1;
  fmsp_pkg::fmsp_sfr_req_s sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic tx_space;
  logic rxd_out;
  logic rxd_oe;
  logic txd_out;
  logic rxd_in;
  logic ph = 1'b0;
  logic t1_ovf = 1'b0;
  logic t2_ovf = 1'b0;
  logic baud_double = 1'b0;
  logic rx_clock_source = 1'b0;
  logic tx_clock_source = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  logic [10:0] fr;
  logic [7:0] rv;
  int len;

  // 50 MHz clock, and overflow pulses every second cycle
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ph <= ~ph;
    t1_ovf <= ph;
    t2_ovf <= ph;
  end

  fmsp_top #(.FIFO_DEPTH(16)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .tx_space(tx_space),
    .t1_ovf(t1_ovf), .t2_ovf(t2_ovf), .baud_double(baud_double),
    .rx_clock_source(rx_clock_source), .tx_clock_source(tx_clock_source),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out)
  );
  fmsp_remote remote_u (
    .sys_clk(sys_clk), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare, register cycles, verdict
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    sfr_req.rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({3'h0, d}, {3'h0, exp});
  endtask : rdchk

  // transmit one frame and check its bits, bit length and done flag
  task automatic txc(input logic [7:0] c, input logic [7:0] d, input int cyc, input int n,
                     input logic [10:0] e);
    wr(CTL, c);
    wr(DAT, d);
    remote_u.recv(cyc, n, fr, len);
    check(fr, e);
    check(11'(len), 11'(cyc));
    rdchk(CTL, c | 8'h02);
    // let the stop bit finish before the next mode or rate change
    repeat (cyc) @(posedge sys_clk);
  endtask : txc

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial begin
    arst_n <= 1'b0; // edge seen by every reset branch
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdchk(CTL, fmsp_pkg::CTL_RST);
    rdchk(8'h55, 8'h00);
    wr(CTL, 8'hf8);
    rdchk(CTL, 8'hf8);
    $display("test registers done");
    // fixed 9-bit mode, normal and doubled rate
    txc(8'h88, 8'ha5, 64, 11, {2'b11, 8'ha5, 1'b0});
    @(posedge sys_clk);
    baud_double <= 1'b1;
    txc(8'h80, 8'h3d, 32, 11, {2'b10, 8'h3d, 1'b0});
    // 8-bit mode on timer 1 doubled, then 9-bit variable mode on timer 2
    txc(8'h48, 8'h81, 32, 10, {2'b01, 8'h81, 1'b0});
    @(posedge sys_clk);
    baud_double <= 1'b0;
    tx_clock_source <= 1'b1;
    txc(8'hc8, 8'he7, 32, 11, {2'b11, 8'he7, 1'b0});
    $display("test transmit done");
    // 9-bit receive, overrun, address filter
    wr(CTL, 8'h90);
    remote_u.send(64, 11, {2'b11, 8'h96, 1'b0});
    rdchk(CTL, 8'h95);
    rdchk(DAT, 8'h96);
    remote_u.send(64, 11, {2'b11, 8'h11, 1'b0});
    rdchk(DAT, 8'h96);
    wr(CTL, 8'hb0);
    remote_u.send(64, 11, {2'b10, 8'h22, 1'b0});
    rdchk(CTL, 8'hb0);
    remote_u.send(64, 11, {2'b11, 8'h33, 1'b0});
    rdchk(CTL, 8'hb5);
    rdchk(DAT, 8'h33);
    $display("test receive 9-bit done");
    // 8-bit receive on timer 2, stop bit filter
    @(posedge sys_clk);
    rx_clock_source <= 1'b1;
    wr(CTL, 8'h70);
    remote_u.send(32, 10, {2'b00, 8'h5a, 1'b0});
    rdchk(CTL, 8'h70);
    remote_u.send(32, 10, {2'b01, 8'h5a, 1'b0});
    rdchk(CTL, 8'h75);
    rdchk(DAT, 8'h5a);
    wr(CTL, 8'h50);
    remote_u.send(32, 10, {2'b00, 8'hc3, 1'b0});
    rdchk(CTL, 8'h51);
    // disabled receiver, then a false start
    wr(CTL, 8'h40);
    remote_u.send(32, 10, {2'b01, 8'h12, 1'b0});
    rdchk(CTL, 8'h40);
    wr(CTL, 8'h50);
    remote_u.send(4, 1, 11'h000);
    repeat (40) @(posedge sys_clk);
    rdchk(CTL, 8'h50);
    remote_u.send(32, 10, {2'b01, 8'h24, 1'b0});
    rdchk(CTL, 8'h55);
    $display("test receive 8-bit done");
    // shift register transmit, multiprocessor enable kept clear
    wr(CTL, 8'h00);
    wr(DAT, 8'hc5);
    remote_u.shift_cap(rv);
    check({3'h0, rv}, 11'h0c5);
    repeat (4) @(posedge sys_clk);
    rdchk(CTL, 8'h02);
    // shift register receive starts once enabled with the flag clear
    wr(CTL, 8'h10);
    remote_u.shift_give(8'h6b);
    rdchk(CTL, 8'h11);
    rdchk(DAT, 8'h6b);
    $display("test shift done");
    end_sim();
  end
endmodule : fmsp_top_tb
